// ### hdl/uhie_pkg.sv
package uhie_pkg;
   // bus geometry
   localparam int          ADDR_W = 8;
   localparam int          DATA_W = 32;
   localparam int          IDX_W  = 6;
   localparam int          EV_W   = 7;
   // register indexes, byte address is four times the index
   localparam logic [5:0]  IDX_STATUS  = 6'h03;
   localparam logic [5:0]  IDX_ENABLE  = 6'h04;
   localparam logic [5:0]  IDX_DISABLE = 6'h05;
   localparam logic [5:0]  IDX_CLEAR   = 6'h06;
   // field positions
   localparam int          BIT_SCHED_OVR  = 0;
   localparam int          BIT_FRAME_BEG  = 2;
   localparam int          BIT_RESUME     = 3;
   localparam int          BIT_FAULT      = 4;
   localparam int          BIT_FRAME_WRAP = 5;
   localparam int          BIT_HUB_CHANGE = 6;
   localparam int          BIT_MASTER     = 31;
   // writable bits of the enable and clear registers
   localparam logic [31:0] EN_MASK  = 32'h8000007D;
   localparam logic [31:0] EV_MASK  = 32'h0000007D;
   // reset values
   localparam logic [31:0] EN_RESET = 32'h00000000;
   localparam logic [31:0] ST_RESET = 32'h00000000;
   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // whole state of the block
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              aw_v;
      logic              w_v;
      logic [7:0]        awaddr;
      logic [31:0]       wdata;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [31:0]       en;
      logic [31:0]       status;
      logic              irq;
   } uhie_state_t;

   localparam uhie_state_t ST_INIT = '{
      awready: 1'b1, wready: 1'b1, aw_v: 1'b0, w_v: 1'b0,
      awaddr: 8'h00, wdata: 32'h00000000, bvalid: 1'b0,
      bresp: 2'h0, arready: 1'b1, rvalid: 1'b0,
      rdata: 32'h00000000, rresp: 2'h0, en: EN_RESET,
      status: ST_RESET, irq: 1'b0};
endpackage

// ### hdl/uhie_irq_ctrl.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
module uhie_irq_ctrl
   import uhie_pkg::*;
(
   aclk,
   aresetn,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   event_pulse,
   irq_out
);
   input  wire logic [ADDR_W-1:0] s_axi_awaddr;
   input  wire logic              aclk;
   input  wire logic              aresetn;
   input  wire logic              s_axi_awvalid;
   output      logic              s_axi_awready;
   input  wire logic [DATA_W-1:0] s_axi_wdata;
   input  wire logic [3:0]        s_axi_wstrb;
   input  wire logic              s_axi_wvalid;
   output      logic              s_axi_wready;
   output      logic [1:0]        s_axi_bresp;
   output      logic              s_axi_bvalid;
   input  wire logic              s_axi_bready;
   input  wire logic [ADDR_W-1:0] s_axi_araddr;
   input  wire logic              s_axi_arvalid;
   output      logic              s_axi_arready;
   output      logic [DATA_W-1:0] s_axi_rdata;
   output      logic [1:0]        s_axi_rresp;
   output      logic              s_axi_rvalid;
   input  wire logic              s_axi_rready;
   input  wire logic [EV_W-1:0]   event_pulse;   // bit layout as enable
   output      logic              irq_out;

   // byte strobes widened to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h00000000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // word index of an aligned byte address
   function automatic logic [IDX_W-1:0] reg_idx(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:2];
   endfunction

   uhie_state_t s_q;          // registered state
   uhie_state_t s_d;          // next state
   logic        wr_go;        // both write halves held, response free
   logic [31:0] ev_word;      // events widened to register layout
   logic [31:0] clr_word;     // status bits cleared by software

   // next-state logic: bus slave, enable register, status, interrupt
   always_comb begin
      s_d      = s_q;
      clr_word = 32'h00000000;
      ev_word  = {{(32-EV_W){1'b0}}, event_pulse} & EV_MASK;
      wr_go    = s_q.aw_v & s_q.w_v & ~s_q.bvalid;
      // write address channel
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_v    = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
         s_d.awready = 1'b0;
      end
      // write data channel, unstrobed lanes read as zero
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_v    = 1'b1;
         s_d.wdata  = s_axi_wdata & strb_mask(s_axi_wstrb);
         s_d.wready = 1'b0;
      end
      // response taken, reopen both write channels
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid  = 1'b0;
         s_d.awready = 1'b1;
         s_d.wready  = 1'b1;
      end
      // commit a write once address and data are both held
      if (wr_go) begin
         s_d.aw_v   = 1'b0;
         s_d.w_v    = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         if (s_q.awaddr[1:0] != 2'b00) begin
            s_d.bresp = RESP_SLVERR;   // misaligned
         end else begin
            case (reg_idx(s_q.awaddr))
               IDX_ENABLE: begin
                  // ones set, zeros keep, reserved ignored
                  s_d.en = s_q.en | (s_q.wdata & EN_MASK);
               end
               IDX_DISABLE: begin
                  // ones clear, zeros keep, master bit included
                  s_d.en = s_q.en & ~(s_q.wdata & EN_MASK);
               end
               IDX_CLEAR: begin
                  clr_word = s_q.wdata & EV_MASK;   // write-one-to-clear status
               end
               IDX_STATUS: begin
                  s_d.bresp = RESP_OKAY;            // read-only, write ignored
               end
               default: begin
                  s_d.bresp = RESP_SLVERR;          // unmapped
               end
            endcase
         end
      end
      // sticky status, a new event wins over a clear
      s_d.status = (s_q.status & ~clr_word) | ev_word;
      // read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = RESP_OKAY;
         s_d.rdata   = 32'h00000000;
         if (s_axi_araddr[1:0] != 2'b00) begin
            s_d.rresp = RESP_SLVERR;         // misaligned
         end else begin
            case (reg_idx(s_axi_araddr))
               IDX_ENABLE: begin
                  s_d.rdata = s_q.en;
               end
               IDX_DISABLE: begin
                  s_d.rdata = s_q.en;
               end
               IDX_STATUS: begin
                  s_d.rdata = s_q.status;
               end
               IDX_CLEAR: begin
                  s_d.rdata = 32'h00000000;  // write-only
               end
               default: begin
                  s_d.rresp = RESP_SLVERR;   // unmapped
               end
            endcase
         end
      end
      // level interrupt gated by master bit and per-event enables
      s_d.irq = s_d.en[BIT_MASTER] & (|(s_d.status & s_d.en & EV_MASK));
   end

   // state register, synchronous reset to zero enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= ST_INIT;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign irq_out       = s_q.irq;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // enable write sets ones and keeps the rest
   property p_en_set;
      wr_go && s_q.awaddr == {IDX_ENABLE, 2'b00}
         |=> s_q.en == ($past(s_q.en) | ($past(s_q.wdata) & EN_MASK));
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable set wrong");

   // disable write clears ones and keeps the rest
   property p_en_clr;
      wr_go && s_q.awaddr == {IDX_DISABLE, 2'b00}
         |=> s_q.en == ($past(s_q.en) & ~($past(s_q.wdata) & EN_MASK));
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("disable clear wrong");

   // reading the disable register returns the enable value
   property p_dis_read;
      s_axi_arvalid && s_q.arready && s_axi_araddr == {IDX_DISABLE, 2'b00}
         |=> s_q.rvalid && s_q.rdata == $past(s_q.en);
   endproperty
   a_dis_read: assert property (p_dis_read) else $error("disable read wrong");

   // reserved enable bits never set
   property p_reserved;
      (s_q.en & ~EN_MASK) == 32'h00000000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   // enables are zero right after reset release
   property p_rst_zero;
      $rose(aresetn) |-> s_q.en == EN_RESET && !irq_out;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("reset value wrong");

   // interrupt follows status, enable and master gate
   property p_irq_gate;
      irq_out == (s_q.en[BIT_MASTER] & (|(s_q.status & s_q.en & EV_MASK)));
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

   // master disable drops the interrupt on the next edge
   property p_master_off;
      wr_go && s_q.awaddr == {IDX_DISABLE, 2'b00} && s_q.wdata[BIT_MASTER]
         |=> !irq_out && !s_q.en[BIT_MASTER];
   endproperty
   a_master_off: assert property (p_master_off) else $error("master off failed");

   // enabled event with master set raises the interrupt next edge
   property p_ev_irq;
      event_pulse[BIT_HUB_CHANGE] && s_q.en[BIT_HUB_CHANGE] && s_q.en[BIT_MASTER]
         && !wr_go |=> irq_out;
   endproperty
   a_ev_irq: assert property (p_ev_irq) else $error("event lost");

   // a committed write is answered on the next edge, write channels closed
   property p_bresp;
      wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");

   // response taken, both write channels reopen
   property p_b_done;
      s_axi_bvalid && s_axi_bready
         |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write channels stuck");

   // read data taken, address channel reopens
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read channel stuck");

   // no second read is taken while data waits
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");

   // reading the enable register returns its current value
   property p_en_read;
      s_axi_arvalid && s_q.arready && s_axi_araddr == {IDX_ENABLE, 2'b00}
         |=> s_q.rvalid && s_q.rdata == $past(s_q.en);
   endproperty
   a_en_read: assert property (p_en_read) else $error("enable read wrong");

   // enables move only on a committed write
   property p_en_hold;
      !wr_go |=> s_q.en == $past(s_q.en);
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("enable changed unasked");

   // a one in the master position of the enable register opens the gate
   property p_master_set;
      wr_go && s_q.awaddr == {IDX_ENABLE, 2'b00} && s_q.wdata[BIT_MASTER]
         |=> s_q.en[BIT_MASTER];
   endproperty
   a_master_set: assert property (p_master_set) else $error("master set failed");

   // a closed gate keeps the interrupt line low
   property p_gate_quiet;
      !s_q.en[BIT_MASTER] |-> !irq_out;
   endproperty
   a_gate_quiet: assert property (p_gate_quiet) else $error("irq with gate closed");

endmodule

// ### sim/uhie_host_model.sv
`timescale 1ns/10ps
// bus master standing in for the host driver software
module uhie_host_model
   import uhie_pkg::*;
(
   input  wire logic              aclk,
   output      logic [ADDR_W-1:0] awaddr,
   output      logic              awvalid,
   input  wire logic              awready,
   output      logic [DATA_W-1:0] wdata,
   output      logic [3:0]        wstrb,
   output      logic              wvalid,
   input  wire logic              wready,
   input  wire logic [1:0]        bresp,
   input  wire logic              bvalid,
   output      logic              bready,
   output      logic [ADDR_W-1:0] araddr,
   output      logic              arvalid,
   input  wire logic              arready,
   input  wire logic [DATA_W-1:0] rdata,
   input  wire logic [1:0]        rresp,
   input  wire logic              rvalid,
   output      logic              rready
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // one write; address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // one read; rready held until the data arrives
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

// ### sim/uhie_irq_ctrl_tb.sv
`timescale 1ns/10ps
// register and interrupt scenarios for the enable/mask block
module uhie_irq_ctrl_tb;
   import uhie_pkg::*;
   logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, irq_out;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata, e;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, r;
   logic [EV_W-1:0]   event_pulse;
   int                mismatches, n_checks, cyc;
   int                ev[6] = '{0, 2, 3, 4, 5, 6};
   // partner and block under test
   uhie_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   uhie_irq_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .event_pulse(event_pulse), .irq_out(irq_out));
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // compare and count
   task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", w, exp, seen);
      end
   endtask
   // verdict
   task automatic complete_run();
      if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // write expecting okay
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   // read and compare
   task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] x);
      host.rd(a, e, r);
      chk(w, e, x);
   endtask
   // let the interrupt line settle, then compare
   task automatic irq_chk(input logic x);
      repeat (2) @(posedge aclk);
      chk("irq_out", {31'h0, irq_out}, {31'h0, x});
   endtask
   // one-cycle event pulse
   task automatic pulse(input int b);
      @(posedge aclk);
      event_pulse <= 7'h01 << b;
      @(posedge aclk);
      event_pulse <= '0;
   endtask
   // values straight after reset
   task automatic t_reset();
      rd_chk("enable", 8'h10, EN_RESET);
      rd_chk("disable", 8'h14, 32'h00000000);
      irq_chk(1'b0);
   endtask
   // set-only writes, reserved bits, disable reads the enable
   task automatic t_set();
      wr(8'h10, 32'h00000005);
      wr(8'h10, 32'h00000040);
      rd_chk("enable", 8'h10, 32'h00000045);
      wr(8'h10, 32'hFFFFFFFF);
      rd_chk("enable", 8'h10, EN_MASK);
      wr(8'h10, 32'h00000000);
      rd_chk("disable", 8'h14, EN_MASK);
   endtask
   // clearing one bit at a time through the disable register
   task automatic t_disable();
      logic [31:0] x;     // enables still standing
      x = EN_MASK;
      wr(8'h14, 32'h00000000);
      wr(8'h14, 32'h7FFFFF82);
      rd_chk("enable", 8'h10, EN_MASK);
      foreach (ev[i]) begin
         wr(8'h14, 32'h1 << ev[i]);
         x = x & ~(32'h1 << ev[i]);
         rd_chk("enable", 8'h10, x);
      end
      wr(8'h14, 32'h80000000);
      rd_chk("enable", 8'h10, 32'h00000000);
   endtask
   // every event through the gate and its own enable
   task automatic t_irq();
      foreach (ev[i]) begin
         wr(8'h18, 32'hFFFFFFFF);
         wr(8'h10, 32'h80000000);
         pulse(ev[i]);
         irq_chk(1'b0);
         wr(8'h10, 32'h1 << ev[i]);
         irq_chk(1'b1);
         wr(8'h18, 32'h1 << ev[i]);
         irq_chk(1'b0);
         pulse(ev[i]);
         irq_chk(1'b1);
         wr(8'h14, 32'h80000000);
         irq_chk(1'b0);
         wr(8'h14, 32'h00000000);
         irq_chk(1'b0);
         wr(8'h10, 32'h80000000);
         irq_chk(1'b1);
         wr(8'h10, 32'h00000000);
         irq_chk(1'b1);
         wr(8'h14, 32'h1 << ev[i]);
         irq_chk(1'b0);
         wr(8'h14, 32'h80000000);
      end
      wr(8'h18, 32'hFFFFFFFF);
      wr(8'h10, 32'hFFFFFFFF);
      pulse(1);
      irq_chk(1'b0);
      wr(8'h14, 32'hFFFFFFFF);
   endtask
   // unmapped place refused without effect
   task automatic t_unmapped();
      host.rd(8'h40, e, r);
      chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      host.wr(8'h40, 32'hFFFFFFFF, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      rd_chk("enable", 8'h10, 32'h00000000);
   endtask
   // reset in mid-run with an interrupt pending
   task automatic t_rerun();
      wr(8'h18, 32'hFFFFFFFF);
      wr(8'h10, EN_MASK);
      pulse(BIT_HUB_CHANGE);
      irq_chk(1'b1);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
   endtask
   // main sequence
   initial begin
      aresetn = 1'b0;
      event_pulse = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_set();
      t_disable();
      t_irq();
      t_unmapped();
      t_rerun();
      complete_run();
   end
endmodule
